// ### hw/bwr_core.sv
// Banked working registers, bit sequential carrier, status word,
// bank select pair and stack pointer of the 4-bit CPU core.
// Assumes the execution unit issues one access per cycle, same clock.
//
// Operation
// - Four banks of eight 4-bit working registers in bank 0 area.
// - Register pairs read and write as 8-bit values; pointers give addresses.
// - 16-bit carrier at FC0H-FC3H, 1/4/8-bit read and write access.
// - Indirect bit access uses low pointer register as carrier bit index.
// - Status word always reachable regardless of bank enable flags.
// - Status word pushed before interrupt service, restored on return.
// - Flags 1/4-bit read/write; 8-bit status access is read-only.
// - Skip flags visible only on 8-bit reads, never written by software.
// - Bank select pair holds memory bank and register bank nibbles.
// - Memory bank select accepts 0,1,2,3,15 as upper address nibble.
// - Register bank select chooses bank 0 to 3.
// - Push/pop of bank select pair moves both values via stack.
// - Memory enable clear limits mem_allowed_out to 00H-7FH of banks 0 and 15; the carrier stays accessible.
// - 8-bit stack pointer addresses bank 0, bit 0 held zero.
`timescale 1ns/1ps
`default_nettype none

module bwr_core
    import bwr_pkg::*;
#(
    parameter int DATA_AW = 12
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Working register port
    input wire logic reg_wr_in,
    input wire logic reg_pair_in,
    input wire logic [2:0] reg_idx_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Data memory mapped carrier port
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [1:0] mem_width_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic [1:0] mem_bit_in,
    input wire logic mem_bit_ind_in,
    input wire logic [7:0] mem_wdata_in,
    output logic [7:0] mem_rdata_out,
    output logic [DATA_AW-1:0] mem_full_addr_out,
    output logic mem_allowed_out,
    // Status word port
    input wire logic psw_rd_in,
    input wire logic psw_wr_in,
    input wire logic [1:0] psw_width_in,
    input wire logic [2:0] psw_bit_in,
    input wire logic psw_nib_in,
    input wire logic [3:0] psw_wdata_in,
    input wire logic [2:0] skip_set_in,
    input wire logic skip_load_in,
    input wire logic carry_set_in,
    input wire logic carry_load_in,
    output logic [7:0] psw_rdata_out,
    // Bank select instructions
    input wire logic smb_wr_in,
    input wire logic [3:0] smb_val_in,
    input wire logic srb_wr_in,
    input wire logic [3:0] srb_val_in,
    output logic smb_reject_out,
    // Stack save and restore
    input wire logic psw_push_in,
    input wire logic psw_pop_in,
    input wire logic [7:0] psw_pop_data_in,
    input wire logic sb_push_in,
    input wire logic sb_pop_in,
    input wire logic [7:0] sb_pop_data_in,
    output logic [7:0] stack_wdata_out,
    // Stack pointer
    input wire logic sp_wr_in,
    input wire logic [7:0] sp_wdata_in,
    output logic [7:0] sp_out,
    output logic [7:0] sp_addr_out,
    // Visible state
    output logic [3:0] smb_out,
    output logic [3:0] srb_out,
    output logic [1:0] reg_bank_out,
    output logic [7:0] pair_ptr_out,
    output logic [7:0] pair_acc_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_AW != 12) begin : g_bad_aw
        $error("bwr_core: data address must be 12 bits");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int NREG = BWR_BANKS * BWR_REGS_PER_BANK;
    logic [3:0] wreg_q [NREG];
    logic [3:0] wreg_d [NREG];
    logic [15:0] carrier_q, carrier_d;
    logic [7:0] psw_q, psw_d;
    logic [3:0] smb_q, smb_d;
    logic [1:0] srb_q, srb_d;
    logic [7:0] sp_q, sp_d;
    logic [7:0] reg_rdata_q, reg_rdata_d;
    logic [7:0] mem_rdata_q, mem_rdata_d;
    logic [7:0] psw_rdata_q, psw_rdata_d;
    logic [7:0] stack_q, stack_d;
    logic smb_rej_q, smb_rej_d;
    logic [DATA_AW-1:0] full_addr_q, full_addr_d;
    logic allowed_q, allowed_d;
    logic [1:0] vbank_q, vbank_d;
    logic [7:0] pair_ptr_q, pair_ptr_d, pair_acc_q, pair_acc_d;

    // Effective bank and flat indices
    logic [1:0] bank;
    logic [4:0] base;
    logic [4:0] even_idx;
    logic [4:0] odd_idx;
    logic [4:0] lptr_idx;
    logic [3:0] bitpos;
    logic carrier_hit;
    logic [1:0] nib;

    // Bank choice honours register enable flag
    always_comb begin
        bank = psw_q[BWR_PSW_REGBANK_EN] ? srb_q : 2'h0;
        base = {bank, 3'h0};
        even_idx = base | {2'h0, reg_idx_in[2:1], 1'b0};
        odd_idx = base | {2'h0, reg_idx_in[2:1], 1'b1};
        lptr_idx = base | {2'h0, BWR_REG_LOW_PTR};
        carrier_hit = (mem_addr_in >= BWR_CARRIER_BASE[7:0])
            && (mem_addr_in <= BWR_CARRIER_LAST[7:0])
            && smb_q == BWR_IO_BANK;
        nib = mem_addr_in[1:0] - BWR_CARRIER_BASE[1:0];
        // Indirect: bit index from low pointer register
        bitpos = mem_bit_ind_in ? wreg_q[lptr_idx]
                                : {nib, mem_bit_in};
    end

    // ------------------------------------------------------------
    // Working registers
    // ------------------------------------------------------------
    // Nibble or pair write into the active bank
    always_comb begin
        wreg_d = wreg_q;
        reg_rdata_d = reg_rdata_q;
        if (reg_wr_in) begin
            if (reg_pair_in) begin
                wreg_d[even_idx] = reg_wdata_in[3:0];
                wreg_d[odd_idx] = reg_wdata_in[7:4];
            end else begin
                wreg_d[base | {2'h0, reg_idx_in}] = reg_wdata_in[3:0];
            end
        end
        if (reg_pair_in) begin
            reg_rdata_d = {wreg_q[odd_idx], wreg_q[even_idx]};
        end else begin
            reg_rdata_d = {4'h0, wreg_q[base | {2'h0, reg_idx_in}]};
        end
    end

    // ------------------------------------------------------------
    // Carrier and memory bank gating
    // ------------------------------------------------------------
    always_comb begin
        carrier_d = carrier_q;
        mem_rdata_d = mem_rdata_q;
        // Low area only of banks 0 and 15 when enable is clear
        if (psw_q[BWR_PSW_MEMBANK_EN]) begin
            allowed_d = 1'b1;
        end else begin
            allowed_d = (smb_q == 4'h0 || smb_q == BWR_IO_BANK)
                && mem_addr_in <= BWR_LOW_AREA_LAST;
        end
        full_addr_d = {smb_q, mem_addr_in};
        if (carrier_hit && (mem_rd_in || mem_wr_in)) begin
            unique case (bwr_width_e'(mem_width_in))
                BWR_W1: begin
                    mem_rdata_d = {7'h00, carrier_q[bitpos]};
                    if (mem_wr_in) begin
                        carrier_d[bitpos] = mem_wdata_in[0];
                    end
                end
                BWR_W4: begin
                    mem_rdata_d = {4'h0, carrier_q[nib*4 +: 4]};
                    if (mem_wr_in) begin
                        carrier_d[nib*4 +: 4] = mem_wdata_in[3:0];
                    end
                end
                default: begin
                    // 8-bit uses even nibble pair
                    mem_rdata_d = carrier_q[nib[1]*8 +: 8];
                    if (mem_wr_in) begin
                        carrier_d[nib[1]*8 +: 8] = mem_wdata_in;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status word, bank select, stack pointer
    // ------------------------------------------------------------
    always_comb begin
        psw_d = psw_q;
        smb_d = smb_q;
        srb_d = srb_q;
        sp_d = sp_q;
        stack_d = stack_q;
        smb_rej_d = 1'b0;
        psw_rdata_d = psw_rdata_q;
        // Hardware flag updates
        if (carry_load_in) begin
            psw_d[BWR_PSW_CARRY] = carry_set_in;
        end
        if (skip_load_in) begin
            psw_d[BWR_PSW_SKIP_LSB +: 3] = skip_set_in;
        end
        // Software access, independent of enable flags
        if (psw_rd_in) begin
            unique case (bwr_width_e'(psw_width_in))
                BWR_W1: psw_rdata_d = {7'h00, psw_q[psw_bit_in]
                    && psw_bit_in >= 3'(BWR_PSW_CARRY)};
                BWR_W4: psw_rdata_d = {4'h0,
                    psw_nib_in ? psw_q[7:4] : {psw_q[3], 3'h0}};
                default: psw_rdata_d = psw_q;
            endcase
        end
        if (psw_wr_in) begin
            unique case (bwr_width_e'(psw_width_in))
                BWR_W1: begin
                    if (psw_bit_in >= 3'(BWR_PSW_CARRY)) begin
                        psw_d[psw_bit_in] = psw_wdata_in[0];
                    end
                end
                BWR_W4: begin
                    if (psw_nib_in) begin
                        psw_d[7:4] = psw_wdata_in;
                    end else begin
                        psw_d[BWR_PSW_CARRY] = psw_wdata_in[3];
                    end
                end
                default: ;
            endcase
        end
        // Interrupt save/restore
        if (psw_push_in) begin
            stack_d = psw_q;
        end
        if (psw_pop_in) begin
            psw_d = psw_pop_data_in;
        end
        // Bank select instructions
        if (smb_wr_in) begin
            if (smb_val_in <= 4'h3 || smb_val_in == BWR_IO_BANK) begin
                smb_d = smb_val_in;
            end else begin
                smb_rej_d = 1'b1;
            end
        end
        if (srb_wr_in) begin
            srb_d = srb_val_in[1:0];
        end
        if (sb_push_in) begin
            stack_d = {smb_q, 2'h0, srb_q};
        end
        if (sb_pop_in) begin
            smb_d = sb_pop_data_in[7:4];
            srb_d = sb_pop_data_in[1:0];
        end
        if (sp_wr_in) begin
            sp_d = {sp_wdata_in[7:1], 1'b0};
        end
        vbank_d = psw_d[BWR_PSW_REGBANK_EN] ? srb_d : 2'h0;
        pair_ptr_d = {wreg_d[{vbank_d, 3'h7}], wreg_d[{vbank_d, 3'h6}]};
        pair_acc_d = {wreg_d[{vbank_d, 3'h1}], wreg_d[{vbank_d, 3'h0}]};
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wreg_q <= '{default: 4'h0};
            carrier_q <= BWR_CARRIER_RESET;
            psw_q <= BWR_PSW_RESET;
            smb_q <= BWR_SMB_RESET;
            srb_q <= BWR_SRB_RESET;
            sp_q <= BWR_SP_RESET;
            reg_rdata_q <= 8'h00;
            mem_rdata_q <= 8'h00;
            psw_rdata_q <= 8'h00;
            stack_q <= 8'h00;
            smb_rej_q <= 1'b0;
            full_addr_q <= '0;
            allowed_q <= 1'b0;
            vbank_q <= 2'h0;
            pair_ptr_q <= 8'h00;
            pair_acc_q <= 8'h00;
        end else begin
            wreg_q <= wreg_d;
            carrier_q <= carrier_d;
            psw_q <= psw_d;
            smb_q <= smb_d;
            srb_q <= srb_d;
            sp_q <= sp_d;
            reg_rdata_q <= reg_rdata_d;
            mem_rdata_q <= mem_rdata_d;
            psw_rdata_q <= psw_rdata_d;
            stack_q <= stack_d;
            smb_rej_q <= smb_rej_d;
            full_addr_q <= full_addr_d;
            allowed_q <= allowed_d;
            vbank_q <= vbank_d;
            pair_ptr_q <= pair_ptr_d;
            pair_acc_q <= pair_acc_d;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_out = reg_rdata_q;
    assign mem_rdata_out = mem_rdata_q;
    assign mem_full_addr_out = full_addr_q;
    assign mem_allowed_out = allowed_q;
    assign psw_rdata_out = psw_rdata_q;
    assign smb_reject_out = smb_rej_q;
    assign stack_wdata_out = stack_q;
    assign sp_out = sp_q;
    assign sp_addr_out = sp_q;
    assign smb_out = smb_q;
    assign srb_out = {2'h0, srb_q};
    assign reg_bank_out = vbank_q;
    assign pair_ptr_out = pair_ptr_q;
    assign pair_acc_out = pair_acc_q;

endmodule : bwr_core

`default_nettype wire

// ### hw/bwr_pkg.sv
// Package for the banked working register file and control state.
// Assumes a 4-bit core issuing 1/4/8-bit accesses on one CPU clock.
package bwr_pkg;

    // Access widths
    typedef enum logic [1:0] {
        BWR_W1,
        BWR_W4,
        BWR_W8
    } bwr_width_e;

    // Geometry
    localparam int BWR_BANKS = 4;
    localparam int BWR_REGS_PER_BANK = 8;

    // Carrier placement in data memory
    localparam logic [11:0] BWR_CARRIER_BASE = 12'hfc0;
    localparam logic [11:0] BWR_CARRIER_LAST = 12'hfc3;

    // Working register pair indices (even register of each pair) and the low pointer register index
    localparam logic [2:0] BWR_PAIR_ACC = 3'h0;
    localparam logic [2:0] BWR_PAIR_PTR1 = 3'h2;
    localparam logic [2:0] BWR_PAIR_PTR2 = 3'h4;
    localparam logic [2:0] BWR_PAIR_PTR3 = 3'h6;
    localparam logic [2:0] BWR_REG_LOW_PTR = 3'h1;

    // Status word field positions
    localparam int BWR_PSW_SKIP_LSB = 0;
    localparam int BWR_PSW_CARRY = 3;
    localparam int BWR_PSW_REGBANK_EN = 4;
    localparam int BWR_PSW_MEMBANK_EN = 5;
    localparam int BWR_PSW_IS_LOW = 6;
    localparam int BWR_PSW_IS_HIGH = 7;

    // Reset values
    localparam logic [7:0] BWR_PSW_RESET = 8'h00;
    localparam logic [3:0] BWR_SMB_RESET = 4'h0;
    localparam logic [1:0] BWR_SRB_RESET = 2'h0;
    localparam logic [15:0] BWR_CARRIER_RESET = 16'h0000;
    localparam logic [7:0] BWR_SP_RESET = 8'h00;

    // Bank limits
    localparam logic [3:0] BWR_IO_BANK = 4'hf;
    localparam logic [7:0] BWR_LOW_AREA_LAST = 8'h7f;

endpackage : bwr_pkg

// ### verification/bwr_asserts.sv
// Concurrent checks on the register file core ports.
// Assumes binding to bwr_core: one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bwr_asserts (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic reg_wr_in,
    input wire logic reg_pair_in,
    input wire logic [2:0] reg_idx_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic smb_wr_in,
    input wire logic [3:0] smb_val_in,
    input wire logic srb_wr_in,
    input wire logic [3:0] srb_val_in,
    input wire logic smb_reject_out,
    input wire logic psw_wr_in,
    input wire logic psw_pop_in,
    input wire logic sb_push_in,
    input wire logic sb_pop_in,
    input wire logic [7:0] sb_pop_data_in,
    input wire logic [7:0] stack_wdata_out,
    input wire logic sp_wr_in,
    input wire logic [7:0] sp_wdata_in,
    input wire logic [7:0] sp_out,
    input wire logic [7:0] sp_addr_out,
    input wire logic [3:0] smb_out,
    input wire logic [3:0] srb_out,
    input wire logic [7:0] pair_acc_out
);
    // ----------------------------------------
    // Bank select, stack and pair checks
    // ----------------------------------------
    logic smb_ok;
    logic bank_quiet;
    // Legal memory banks; no register bank change in flight
    assign smb_ok = smb_val_in < 4'h4 || smb_val_in == 4'hf;
    assign bank_quiet = !(srb_wr_in || sb_pop_in || psw_pop_in || psw_wr_in);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    sequence bad_smb_s;
        smb_wr_in && !smb_ok && !sb_pop_in;
    endsequence
    sequence refused_s;
        smb_reject_out && $stable(smb_out);
    endsequence
    sp_even_a: assert property (!sp_out[0] && !sp_addr_out[0])
        else $error("stack pointer bit zero set");
    sp_load_a: assert property (sp_wr_in |=>
        sp_out == ($past(sp_wdata_in) & 8'hfe)) else $error("sp load bad");
    smb_refuse_a: assert property (bad_smb_s |=> refused_s)
        else $error("illegal bank accepted");
    smb_take_a: assert property (smb_wr_in && smb_ok && !sb_pop_in |=>
        smb_out == $past(smb_val_in) && !smb_reject_out)
        else $error("legal bank not taken");
    srb_take_a: assert property (srb_wr_in && !sb_pop_in |=>
        srb_out == ($past(srb_val_in) & 4'h3)) else $error("srb bad");
    sb_push_a: assert property (sb_push_in |=>
        stack_wdata_out == {$past(smb_out), $past(srb_out) & 4'h3})
        else $error("bank pair push word bad");
    sb_pop_a: assert property (sb_pop_in |=>
        {smb_out, srb_out} == ($past(sb_pop_data_in) & 8'hf3))
        else $error("bank pair pop bad");
    pair_write_a: assert property (reg_wr_in && reg_pair_in &&
        reg_idx_in == 3'h0 && bank_quiet |=>
        pair_acc_out == $past(reg_wdata_in)) else $error("pair write lost");
endmodule // bwr_asserts

bind bwr_core bwr_asserts u_chk (.*);
`default_nettype wire

// ### verification/bwr_stack_model.sv
// Stack memory on the far side of the core's push and pop strobes.
// Assumes one clock; the pushed word is valid one cycle after push.
`timescale 1ns/1ps
`default_nettype none
module bwr_stack_model (
    input wire logic clk_sys_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [7:0] stack_wdata_in,
    output logic [7:0] pop_data_out
);
    // ----------------------------------------
    // Word storage, newest on top
    // ----------------------------------------
    logic push_q = 1'b0;
    logic [7:0] mem [$];
    initial pop_data_out = 8'h5a;
    // Word lands a cycle late; an empty top toggles every cycle
    always @(posedge clk_sys_in) begin
        if (push_q) mem.push_back(stack_wdata_in);
        if (pop_in && mem.size() > 0) void'(mem.pop_back());
        push_q <= push_in;
        pop_data_out <= mem.size() > 0 ? mem[$] : ~pop_data_out;
    end
endmodule // bwr_stack_model
`default_nettype wire

// ### verification/test_bwr.sv
// Self-checking bench for the banked register file core.
// Assumes bwr_core, bwr_stack_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_banked_working_register_file;
    // ----------------------------------------
    // Stimulus, model state and checking
    // ----------------------------------------
    logic clk_sys_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_pair_in = 0;
    logic mem_rd_in = 0, mem_wr_in = 0, mem_bit_ind_in = 0, psw_rd_in = 0;
    logic psw_wr_in = 0, psw_nib_in = 0, skip_load_in = 0, carry_set_in = 0;
    logic carry_load_in = 0, smb_wr_in = 0, srb_wr_in = 0, psw_push_in = 0;
    logic psw_pop_in = 0, sb_push_in = 0, sb_pop_in = 0, sp_wr_in = 0;
    logic [1:0] mem_width_in = 0, mem_bit_in = 0, psw_width_in = 0;
    logic [2:0] reg_idx_in = 0, psw_bit_in = 0, skip_set_in = 0;
    logic [3:0] psw_wdata_in = 0, smb_val_in = 0, srb_val_in = 0;
    logic [7:0] reg_wdata_in = 0, mem_addr_in = 0, mem_wdata_in = 0;
    logic [7:0] sp_wdata_in = 0, pop_word, reg_rdata_out, mem_rdata_out;
    logic [7:0] psw_rdata_out, stack_wdata_out, sp_out, sp_addr_out;
    logic [7:0] pair_ptr_out, pair_acc_out;
    logic [11:0] mem_full_addr_out;
    logic [3:0] smb_out, srb_out;
    logic [1:0] reg_bank_out;
    logic mem_allowed_out, smb_reject_out;
    int n_mismatch = 0, num_checks = 0, seed = 85278, m_smb, r;
    int m_pair [4];
    bwr_core dut_u (.*, .psw_pop_data_in(pop_word), .sb_pop_data_in(pop_word));
    bwr_stack_model stk_u (.clk_sys_in(clk_sys_in),
        .push_in(psw_push_in | sb_push_in), .pop_in(psw_pop_in | sb_pop_in),
        .stack_wdata_in(stack_wdata_out), .pop_data_out(pop_word));
    always #12.5 clk_sys_in = ~clk_sys_in;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick();
        @(negedge clk_sys_in);
    endtask
    // Status word write (bit 2 of b picks the upper nibble), then read back
    task automatic psw_op(input logic [1:0] w, input logic [2:0] b,
                          input logic [3:0] d, input logic [7:0] exp);
        psw_wr_in = 1;
        psw_width_in = w;
        psw_bit_in = b;
        psw_nib_in = b[2];
        psw_wdata_in = d;
        tick();
        psw_wr_in = 0;
        psw_rd_in = 1;
        psw_width_in = 2'h2;
        tick();
        psw_rd_in = 0;
        chk(psw_rdata_out, exp, "status word");
    endtask
    task automatic mem_op(input logic wr, input logic [1:0] w,
                          input logic [7:0] a, input logic [7:0] d);
        mem_wr_in = wr;
        mem_rd_in = !wr;
        mem_width_in = w;
        mem_addr_in = a;
        mem_wdata_in = d;
        tick();
        mem_wr_in = 0;
        mem_rd_in = 0;
    endtask
    task automatic bank_op(input logic sm, input logic [3:0] mv,
                           input logic sr, input logic [3:0] rv);
        smb_wr_in = sm;
        smb_val_in = mv;
        srb_wr_in = sr;
        srb_val_in = rv;
        tick();
        smb_wr_in = 0;
        srb_wr_in = 0;
    endtask
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        n_mismatch++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_in);
        tick();
        rst_b_in = 1;
        tick();
        chk({smb_out, srb_out, sp_out}, 0, "reset state");
        psw_op(2'h2, 3'h0, 4'hf, 8'h00);
        psw_op(2'h1, 3'h4, 4'h1, 8'h10);
        psw_op(2'h0, 3'h3, 4'h1, 8'h18);
        psw_op(2'h0, 3'h1, 4'h1, 8'h18);
        skip_set_in = 3'h5;
        skip_load_in = 1;
        tick();
        skip_load_in = 0;
        psw_op(2'h2, 3'h0, 4'h0, 8'h1d);
        psw_op(2'h1, 3'h0, 4'h0, 8'h15);
        for (int b = 0; b < 8; b++) begin
            bank_op(0, 0, 1, 4'(b));
            chk(srb_out, b % 4, "register bank");
            if (b < 4) begin
                reg_wr_in = 1;
                reg_pair_in = 1;
                m_pair[b] = $random(seed) & 8'hff;
                reg_wdata_in = 8'(m_pair[b]);
                tick();
                reg_wr_in = 0;
            end
            chk(pair_acc_out, m_pair[b % 4], "pair");
        end
        psw_op(2'h1, 3'h4, 4'h0, 8'h05);
        tick();
        chk({reg_bank_out, pair_acc_out}, m_pair[0], "bank zero");
        for (int v = 0; v < 16; v++) begin
            bank_op(1, 4'(v), 0, 0);
            if (v < 4 || v == 15) m_smb = v;
            chk(smb_reject_out, !(v < 4 || v == 15), "refusal");
            chk(smb_out, m_smb, "memory bank");
        end
        mem_op(0, 2'h2, 8'hc2, 0);
        chk(mem_allowed_out, 0, "bank gate off");
        psw_op(2'h1, 3'h4, 4'h2, 8'h25);
        r = $random(seed) & 8'hff;
        mem_op(1, 2'h2, 8'hc2, 8'(r));
        mem_op(0, 2'h2, 8'hc2, 0);
        chk(mem_rdata_out, r, "carrier byte");
        chk(mem_full_addr_out, 12'hfc2, "full address");
        chk(mem_allowed_out, 1, "bank gate on");
        mem_op(0, 2'h1, 8'hc3, 0);
        chk(mem_rdata_out[3:0], r[7:4], "carrier nibble");
        // Clear high byte, then set one bit through the low pointer
        mem_op(1, 2'h2, 8'hc2, 8'h00);
        r = $random(seed) & 8'hff;
        reg_wr_in = 1;
        reg_idx_in = 3'h6;
        reg_wdata_in = 8'(r);
        tick();
        reg_pair_in = 0;
        reg_idx_in = 3'h1;
        tick();
        reg_wr_in = 0;
        chk(pair_ptr_out, r, "pointer pair");
        mem_bit_ind_in = 1;
        mem_op(1, 2'h0, 8'hc0, 8'h01);
        mem_bit_ind_in = 0;
        chk(reg_rdata_out, r & 8'h0f, "low pointer");
        mem_bit_in = r[1:0];
        mem_op(0, 2'h0, 8'hc0 | {6'h00, r[3:2]}, 0);
        chk(mem_rdata_out, 1, "carrier bit");
        mem_op(0, 2'h2, 8'hc0 | {6'h00, r[3], 1'b0}, 0);
        chk(mem_rdata_out, 8'h01 << r[2:0], "carrier bit byte");
        sp_wdata_in = 8'($random(seed)) | 8'h01;
        sp_wr_in = 1;
        tick();
        sp_wr_in = 0;
        chk(sp_out, sp_wdata_in & 8'hfe, "stack pointer");
        sb_push_in = 1;
        tick();
        sb_push_in = 0;
        bank_op(1, 4'h1, 1, 4'h0);
        sb_pop_in = 1;
        tick();
        sb_pop_in = 0;
        chk({smb_out, srb_out}, 8'hf3, "bank pair restore");
        psw_push_in = 1;
        tick();
        psw_push_in = 0;
        psw_op(2'h1, 3'h4, 4'hc, 8'hc5);
        psw_pop_in = 1;
        tick();
        psw_pop_in = 0;
        psw_op(2'h2, 3'h0, 4'h0, 8'h25);
        // Hardware carry load, then single-bit reads of carry and a skip bit
        carry_set_in = 1;
        carry_load_in = 1;
        psw_bit_in = 3'h3;
        psw_width_in = 2'h0;
        tick();
        carry_load_in = 0;
        psw_rd_in = 1;
        tick();
        chk(psw_rdata_out, 1, "carry bit");
        psw_bit_in = 3'h0;
        tick();
        psw_rd_in = 0;
        chk(psw_rdata_out, 0, "skip bit hidden");
        print_verdict();
    end
endmodule // test_banked_working_register_file
`default_nettype wire
